// ### rtl/dimd_pkg.sv
package dimd_pkg;
  localparam int unsigned TERM_N     = 9;
  localparam int unsigned MODE_W     = 5;
  // Terminal positions
  localparam int unsigned T_STOP     = 0;
  localparam int unsigned T_ENABLE   = 1;
  localparam int unsigned T_START    = 2;
  localparam int unsigned T_DIR_FWD  = 3;
  localparam int unsigned T_REV      = 4;
  localparam int unsigned T_OPT0     = 5;
  localparam int unsigned T_OPT1     = 6;
  localparam int unsigned T_OPT2     = 7;
  localparam int unsigned T_AUX      = 8;
  // Input-mode bounds
  localparam logic [4:0] MODE_PANEL   = 5'h01;
  localparam logic [4:0] MODE_3W_MIN  = 5'h02;
  localparam logic [4:0] MODE_PB_MIN  = 5'h07;
  localparam logic [4:0] MODE_2W_MIN  = 5'h0C;
  localparam logic [4:0] MODE_MAX     = 5'h10;
  // Reference source codes
  localparam logic [2:0] REF_HOLD     = 3'h0;
  localparam logic [2:0] REF_EXT1     = 3'h1;
  // Reset values
  localparam logic [4:0] MODE_RST     = 5'h01;
  localparam logic [2:0] REF_RST      = 3'h1;

  typedef enum logic [1:0] {GRP_PANEL, GRP_3W_MAINT, GRP_3W_PB, GRP_2W} dimd_grp_t;

  typedef struct packed {
    logic       cap_done;
    logic [4:0] mode;
    logic       run;
    logic       rev;
    logic       out_en;
    logic       aux_fault;
    logic [2:0] ref_src;
    logic [1:0] accel_sel;
    logic [1:0] stop_mode;
    logic       pot_up;
    logic       pot_down;
    logic       local_ctl;
  } dimd_state_t;
endpackage : dimd_pkg

// ### rtl/dimd_decoder.sv
// Notes on behaviour
// RULE_01 - Nine terminal inputs; their functions follow the active input mode.
// RULE_02 - Start, stop, reverse, pot, ramp, speed, enable, aux, stop-mode, run, local functions.
// RULE_03 - Terminals map to the function set chosen by the stored mode number.
// RULE_04 - Mode setting may change anytime; mapping changes only after reset.
// RULE_05 - Without option board, configuration must set mode 1 and fit jumpers.
// RULE_06 - Mode 1: terminals give stop and enable; start, direction from panel/comm.
// RULE_07 - Modes 2-6: three-wire start in parallel; maintained direction from one source.
// RULE_08 - Modes 7-11: start, stop, forward, reverse pushbuttons parallel with panel/comm.
// RULE_09 - Modes 12-16: two-wire run forward/reverse; panel/comm run commands ignored.
// RULE_10 - Three speed selects pick hold, ext ref 1, presets 1-5, ext ref 2.
// RULE_11 - Closed speed select reads one, open reads zero.
// RULE_12 - Output section inhibited whenever enable input is false.
// RULE_13 - Auxiliary fault raised whenever auxiliary interlock is open.
// RULE_14 - Three-wire start latches run until stop opens or a fault occurs.
module dimd_decoder (
  input  wire logic                        sys_clk_i,
  input  wire logic                        reset_n_i,
  input  wire logic [dimd_pkg::TERM_N-1:0] terminal_i,  // see RULE_01
  input  wire logic [dimd_pkg::MODE_W-1:0] mode_cfg_i,
  input  wire logic                        dir_from_term_i,
  input  wire logic                        fault_i,
  input  wire logic                        panel_start_i,
  input  wire logic                        panel_stop_i,
  input  wire logic                        panel_fwd_i,
  input  wire logic                        panel_rev_i,
  input  wire logic                        comm_start_i,
  input  wire logic                        comm_stop_i,
  input  wire logic                        comm_fwd_i,
  input  wire logic                        comm_rev_i,
  output logic [dimd_pkg::MODE_W-1:0]      active_mode_o,
  output logic                             mode_ready_o,
  output logic                             run_o,
  output logic                             reverse_o,
  output logic                             output_enable_o,
  output logic                             aux_fault_o,
  output logic [2:0]                       ref_src_o,
  output logic [1:0]                       accel_sel_o,
  output logic [1:0]                       stop_mode_o,
  output logic                             pot_up_o,
  output logic                             pot_down_o,
  output logic                             local_ctl_o
);

  function automatic dimd_pkg::dimd_grp_t grp_of(input logic [4:0] m);
    if (m >= dimd_pkg::MODE_2W_MIN && m <= dimd_pkg::MODE_MAX) begin
      return dimd_pkg::GRP_2W;
    end else if (m >= dimd_pkg::MODE_PB_MIN && m < dimd_pkg::MODE_2W_MIN) begin
      return dimd_pkg::GRP_3W_PB;
    end else if (m >= dimd_pkg::MODE_3W_MIN && m < dimd_pkg::MODE_PB_MIN) begin
      return dimd_pkg::GRP_3W_MAINT;
    end else begin
      return dimd_pkg::GRP_PANEL;
    end
  endfunction : grp_of

  // Position within a group of five; mode 1 and invalid codes use slot 0
  function automatic logic [2:0] slot_of(input logic [4:0] m);
    logic [4:0] d;
    d = 5'h00;
    case (grp_of(m))
      dimd_pkg::GRP_3W_MAINT: d = m - dimd_pkg::MODE_3W_MIN;
      dimd_pkg::GRP_3W_PB:    d = m - dimd_pkg::MODE_PB_MIN;
      dimd_pkg::GRP_2W:       d = m - dimd_pkg::MODE_2W_MIN;
      default:                d = 5'h00;
    endcase
    return d[2:0];
  endfunction : slot_of

  dimd_pkg::dimd_state_t q;
  dimd_pkg::dimd_state_t next_q;

  dimd_pkg::dimd_grp_t grp;
  logic [2:0]          slot;
  logic [2:0]          spd_code;
  logic                stop_ok;
  logic                any_fault;
  logic                start_req;
  logic                stop_req;
  logic                fwd_req;
  logic                rev_req;

  assign grp       = grp_of(q.mode);
  assign slot      = slot_of(q.mode);
  assign stop_ok   = terminal_i[dimd_pkg::T_STOP];
  assign any_fault = fault_i | ~terminal_i[dimd_pkg::T_AUX];

  always_comb begin
    next_q    = q;
    spd_code  = 3'h0;
    start_req = 1'b0;
    stop_req  = 1'b0;
    fwd_req   = 1'b0;
    rev_req   = 1'b0;

    // Mode is sampled once after reset release, then frozen
    if (!q.cap_done) begin
      next_q.cap_done = 1'b1;  // see RULE_04
      next_q.mode     = mode_cfg_i;
    end

    next_q.out_en    = terminal_i[dimd_pkg::T_ENABLE];  // see RULE_12
    next_q.aux_fault = ~terminal_i[dimd_pkg::T_AUX];    // see RULE_13

    // Optional terminals per slot; closed reads as one
    next_q.accel_sel = 2'h0;
    next_q.stop_mode = 2'h0;
    next_q.pot_up    = 1'b0;
    next_q.pot_down  = 1'b0;
    next_q.local_ctl = 1'b0;
    case (slot)  // see RULE_02
      3'h1: begin
        next_q.accel_sel = terminal_i[dimd_pkg::T_OPT1:dimd_pkg::T_OPT0];
        next_q.local_ctl = terminal_i[dimd_pkg::T_OPT2];
      end
      3'h2: begin
        next_q.pot_up   = terminal_i[dimd_pkg::T_OPT0];
        next_q.pot_down = terminal_i[dimd_pkg::T_OPT1];
        spd_code        = {2'h0, terminal_i[dimd_pkg::T_OPT2]};
      end
      3'h3: begin
        next_q.stop_mode = terminal_i[dimd_pkg::T_OPT1:dimd_pkg::T_OPT0];
        spd_code         = {2'h0, terminal_i[dimd_pkg::T_OPT2]};
      end
      3'h4: begin
        spd_code         = {1'b0, terminal_i[dimd_pkg::T_OPT1:dimd_pkg::T_OPT0]};
        next_q.accel_sel = {1'b0, terminal_i[dimd_pkg::T_OPT2]};
      end
      default: begin
        spd_code = terminal_i[dimd_pkg::T_OPT2:dimd_pkg::T_OPT0];  // see RULE_11
      end
    endcase
    if (spd_code != dimd_pkg::REF_HOLD) begin
      next_q.ref_src = spd_code;  // see RULE_10
    end

    // Command sources per group
    case (grp)
      dimd_pkg::GRP_PANEL: begin
        start_req = panel_start_i | comm_start_i;  // see RULE_06
        stop_req  = panel_stop_i | comm_stop_i;
        fwd_req   = panel_fwd_i | comm_fwd_i;
        rev_req   = panel_rev_i | comm_rev_i;
      end
      dimd_pkg::GRP_3W_MAINT: begin
        start_req = terminal_i[dimd_pkg::T_START] | panel_start_i | comm_start_i;  // see RULE_07
        stop_req  = panel_stop_i | comm_stop_i;
        if (dir_from_term_i) begin
          rev_req = terminal_i[dimd_pkg::T_DIR_FWD];
          fwd_req = ~terminal_i[dimd_pkg::T_DIR_FWD];
        end else begin
          fwd_req = panel_fwd_i | comm_fwd_i;
          rev_req = panel_rev_i | comm_rev_i;
        end
      end
      dimd_pkg::GRP_3W_PB: begin
        start_req = terminal_i[dimd_pkg::T_START] | panel_start_i | comm_start_i;  // see RULE_08
        stop_req  = panel_stop_i | comm_stop_i;
        fwd_req   = terminal_i[dimd_pkg::T_DIR_FWD] | panel_fwd_i | comm_fwd_i;
        rev_req   = terminal_i[dimd_pkg::T_REV] | panel_rev_i | comm_rev_i;
      end
      default: begin
        start_req = 1'b0;
      end
    endcase

    if (!q.cap_done) begin
      next_q.run = 1'b0;
    end else if (grp == dimd_pkg::GRP_2W) begin
      // Maintained run inputs; both closed counts as stop
      next_q.run = (terminal_i[dimd_pkg::T_DIR_FWD] ^ terminal_i[dimd_pkg::T_REV])
                   & stop_ok & ~any_fault;  // see RULE_09
      if (terminal_i[dimd_pkg::T_REV] & ~terminal_i[dimd_pkg::T_DIR_FWD]) begin
        next_q.rev = 1'b1;
      end else if (terminal_i[dimd_pkg::T_DIR_FWD] & ~terminal_i[dimd_pkg::T_REV]) begin
        next_q.rev = 1'b0;
      end
    end else begin
      // Stop and faults win over a start in the same cycle
      if (!stop_ok || stop_req || any_fault) begin
        next_q.run = 1'b0;  // see RULE_14
      end else if (start_req) begin
        next_q.run = 1'b1;  // see RULE_14
      end
      if (rev_req && !fwd_req) begin
        next_q.rev = 1'b1;
      end else if (fwd_req && !rev_req) begin
        next_q.rev = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q           <= '0;
      q.mode      <= dimd_pkg::MODE_RST;
      q.ref_src   <= dimd_pkg::REF_RST;
      q.aux_fault <= 1'b1;
    end else begin
      q <= next_q;  // see RULE_03
    end
  end

  assign active_mode_o   = q.mode;
  assign mode_ready_o    = q.cap_done;
  assign run_o           = q.run;
  assign reverse_o       = q.rev;
  assign output_enable_o = q.out_en;
  assign aux_fault_o     = q.aux_fault;
  assign ref_src_o       = q.ref_src;
  assign accel_sel_o     = q.accel_sel;
  assign stop_mode_o     = q.stop_mode;
  assign pot_up_o        = q.pot_up;
  assign pot_down_o      = q.pot_down;
  assign local_ctl_o     = q.local_ctl;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_term_start;
    q.cap_done && (grp == dimd_pkg::GRP_3W_MAINT || grp == dimd_pkg::GRP_3W_PB)
      && terminal_i[dimd_pkg::T_START] && stop_ok && !any_fault && !stop_req;
  endsequence
  sequence s_start_released;
    stop_ok && !any_fault && !stop_req;
  endsequence

  chk_enable_gates_out: assert property (!terminal_i[dimd_pkg::T_ENABLE] |=> !output_enable_o)  // see RULE_12
    else $error("output enabled with enable input open");
  chk_aux_fault_open: assert property (!terminal_i[dimd_pkg::T_AUX] |=> aux_fault_o && !run_o)  // see RULE_13
    else $error("open interlock without aux fault");
  chk_mode_frozen: assert property (q.cap_done |=> $stable(active_mode_o))  // see RULE_04
    else $error("active mode changed without reset");
  chk_start_latch_hold: assert property (s_term_start ##1 s_start_released |=> run_o)  // see RULE_14
    else $error("three-wire run request not latched");
  chk_stop_clears_run: assert property (q.cap_done && grp != dimd_pkg::GRP_2W && !stop_ok |=> !run_o)  // see RULE_14
    else $error("run held with stop input open");
  chk_panel_mode_term: assert property (q.cap_done && grp == dimd_pkg::GRP_PANEL && !run_o
      && !panel_start_i && !comm_start_i |=> !run_o)  // see RULE_06
    else $error("terminal start honoured in mode 1");
  chk_two_wire_panel: assert property (q.cap_done && grp == dimd_pkg::GRP_2W
      && !terminal_i[dimd_pkg::T_DIR_FWD] && !terminal_i[dimd_pkg::T_REV] |=> !run_o)  // see RULE_09
    else $error("panel command honoured in two-wire mode");
  chk_dir_exclusive: assert property (q.cap_done && grp == dimd_pkg::GRP_3W_MAINT && dir_from_term_i
      && !terminal_i[dimd_pkg::T_DIR_FWD] |=> !reverse_o)  // see RULE_07
    else $error("direction taken from second source");
  chk_pb_comm_reverse: assert property (q.cap_done && grp == dimd_pkg::GRP_3W_PB && comm_rev_i
      && !panel_fwd_i && !comm_fwd_i && !terminal_i[dimd_pkg::T_DIR_FWD] |=> reverse_o)  // see RULE_08
    else $error("comm reverse ignored in pushbutton mode");
  chk_speed_hold: assert property (q.cap_done && slot == 3'h0
      && terminal_i[dimd_pkg::T_OPT2:dimd_pkg::T_OPT0] == 3'h0 |=> $stable(ref_src_o))  // see RULE_10
    else $error("reference source moved on hold code");
  chk_speed_closed: assert property (q.cap_done && slot == 3'h0
      && terminal_i[dimd_pkg::T_OPT2:dimd_pkg::T_OPT0] == 3'h7 |=> ref_src_o == 3'h7)  // see RULE_11
    else $error("all closed selects did not give code 7");

endmodule : dimd_decoder

// ### testbench/dimd_contacts.sv
module dimd_contacts (
  input  wire logic       board_present_i,
  input  wire logic [4:0] sel_mode_i,
  input  wire logic [8:0] closed_i,
  output logic      [8:0] terminal_o,
  output logic      [4:0] mode_cfg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Closed contact reads one
  assign terminal_o = closed_i;
  // Without the option board the mode is set to one
  assign mode_cfg_o = board_present_i ? sel_mode_i : dimd_pkg::MODE_PANEL;
endmodule : dimd_contacts

// ### testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk_i = 1'b0, reset_n_i = 1'b0, board = 1'b1;
  logic [4:0] sel_mode = 5'h01, mode_cfg, act_mode;
  logic [8:0] want = 9'h103, term;
  logic       dir_term = 1'b0, fault = 1'b0;
  logic [3:0] pnl = 4'h0, com = 4'h0;
  logic       rdy, run, rev, oen, auxf, pup, pdn, loc;
  logic [2:0] ref_src, exp_ref;
  logic [1:0] accel, stopm;
  int         num_errors = 0, check_count = 0;

  initial forever #5 sys_clk_i = ~sys_clk_i;

  dimd_contacts dimd_contacts_i (.board_present_i(board), .sel_mode_i(sel_mode), .closed_i(want),
    .terminal_o(term), .mode_cfg_o(mode_cfg));

  dimd_decoder dimd_decoder_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .terminal_i(term),
    .mode_cfg_i(mode_cfg), .dir_from_term_i(dir_term), .fault_i(fault),
    .panel_start_i(pnl[0]), .panel_stop_i(pnl[1]), .panel_fwd_i(pnl[2]), .panel_rev_i(pnl[3]),
    .comm_start_i(com[0]), .comm_stop_i(com[1]), .comm_fwd_i(com[2]), .comm_rev_i(com[3]),
    .active_mode_o(act_mode), .mode_ready_o(rdy), .run_o(run), .reverse_o(rev),
    .output_enable_o(oen), .aux_fault_o(auxf), .ref_src_o(ref_src), .accel_sel_o(accel),
    .stop_mode_o(stopm), .pot_up_o(pup), .pot_down_o(pdn), .local_ctl_o(loc));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : tick

  task automatic do_reset(input logic [4:0] m);
    sel_mode = m;
    want = 9'h103;
    reset_n_i = 1'b0;
    tick(10);
    check("reset outs", {run, rev, oen, auxf, rdy, ref_src}, 8'h11);
    reset_n_i = 1'b1;
    tick(2);
    check("mode", {rdy, act_mode}, {3'h1, mode_cfg});
  endtask : do_reset

  // Momentary closure of one source for a cycle
  task automatic press(ref logic [8:0] v, input int idx);
    v[idx] = 1'b1;
    tick(1);
    v[idx] = 1'b0;
    tick(1);
  endtask : press

  task automatic pulse(ref logic [3:0] v, input int idx);
    v[idx] = 1'b1;
    tick(1);
    v[idx] = 1'b0;
    tick(1);
  endtask : pulse

  initial begin
    tick(100000);
    num_errors++;
    final_report();
  end

  initial begin
    void'($urandom(59));
    for (int m = 1; m <= 16; m++) begin
      do_reset(m[4:0]);
    end
    do_reset(5'h02);
    sel_mode = 5'h0C;
    tick(3);
    check("frozen", act_mode, 8'h02);
    press(want, dimd_pkg::T_START);
    check("3w run", run, 1'b1);
    tick(3);
    check("3w hold", run, 1'b1);
    want[dimd_pkg::T_STOP] = 1'b0;
    tick(1);
    check("stop", run, 1'b0);
    want[dimd_pkg::T_STOP] = 1'b1;
    press(want, dimd_pkg::T_START);
    fault = 1'b1;
    tick(1);
    fault = 1'b0;
    check("fault", run, 1'b0);
    dir_term = 1'b1;
    want[dimd_pkg::T_DIR_FWD] = 1'b1;
    tick(1);
    check("term dir", rev, 1'b1);
    pulse(pnl, 2);
    check("panel dir out", rev, 1'b1);
    dir_term = 1'b0;
    pulse(com, 2);
    check("comm dir", rev, 1'b0);
    exp_ref = 3'h1;
    for (int i = 0; i < 300; i++) begin
      want = 9'($urandom);
      {pnl, com} = 8'($urandom);
      fault = 1'($urandom);
      tick(1);
      if (want[7:5] != 3'h0) exp_ref = want[7:5];
      check("enable", oen, want[dimd_pkg::T_ENABLE]);
      check("aux", auxf, !want[dimd_pkg::T_AUX]);
      check("ref", ref_src, exp_ref);
    end
    {pnl, com, fault} = 9'h000;
    board = 1'b0;
    do_reset(5'h0C);
    check("no board", act_mode, 8'h01);
    board = 1'b1;
    press(want, dimd_pkg::T_START);
    check("m1 term start", run, 1'b0);
    pulse(pnl, 0);
    check("m1 panel start", run, 1'b1);
    do_reset(5'h07);
    pulse(pnl, 3);
    check("pb panel rev", rev, 1'b1);
    press(want, dimd_pkg::T_DIR_FWD);
    check("pb term fwd", rev, 1'b0);
    pulse(com, 0);
    check("pb comm start", run, 1'b1);
    do_reset(5'h0C);
    want[dimd_pkg::T_DIR_FWD] = 1'b1;
    tick(1);
    check("2w fwd", {run, rev}, 2'h2);
    want[4:3] = 2'h2;
    tick(1);
    check("2w rev", {run, rev}, 2'h3);
    want[4:3] = 2'h3;
    tick(1);
    check("2w both", {run, rev}, 2'h1);
    want[4:3] = 2'h0;
    pulse(pnl, 0);
    check("2w panel", run, 1'b0);
    do_reset(5'h03);
    want[7:5] = 3'h7;
    tick(1);
    check("accel local", {accel, loc}, 3'h7);
    do_reset(5'h04);
    want[5] = 1'b1;
    tick(1);
    check("pot", {pup, pdn}, 2'h2);
    do_reset(5'h05);
    want[6:5] = 2'h2;
    tick(1);
    check("stop mode", stopm, 2'h2);
    do_reset(5'h06);
    want[7:5] = 3'h7;
    tick(1);
    check("slot4", {ref_src, accel}, 5'h0D);
    final_report();
  end
endmodule : tb
